// ==== rtl/gpio_port_regs.vh ====
// register offsets, reset values and widths of one general-purpose i/o port
// assumes byte addresses on a 32-bit classic wishbone bus, one word per register
`ifndef GPIO_PORT_REGS_VH
`define GPIO_PORT_REGS_VH

// register byte offsets
`define CFG_SEL0_OFS        8'h00
`define CFG_SEL0_SET_OFS    8'h04
`define CFG_SEL0_CLR_OFS    8'h08
`define OUT_EN_OFS          8'h0c
`define OUT_EN_SET_OFS      8'h10
`define OUT_EN_CLR_OFS      8'h14
`define OUT_VAL_OFS         8'h18
`define OUT_VAL_SET_OFS     8'h1c
`define OUT_VAL_CLR_OFS     8'h20
`define PIN_IN_OFS          8'h24
`define IRQ_KIND_OFS        8'h28
`define IRQ_POL_OFS         8'h2c
`define IN_BUF_EN_OFS       8'h30
`define IRQ_EN_OFS          8'h34
`define IRQ_EN_SET_OFS      8'h38
`define IRQ_EN_CLR_OFS      8'h3c
`define IRQ_FLAGS_OFS       8'h40
`define IRQ_FLAGS_CLR_OFS   8'h48
`define WAKE_EN_OFS         8'h4c
`define WAKE_EN_SET_OFS     8'h50
`define WAKE_EN_CLR_OFS     8'h54
`define BOTH_EDGES_OFS      8'h5c
`define PAD_CTRL0_OFS       8'h60
`define PAD_CTRL1_OFS       8'h64
`define CFG_SEL1_OFS        8'h68
`define CFG_SEL1_SET_OFS    8'h6c
`define CFG_SEL1_CLR_OFS    8'h70
`define CFG_SEL2_OFS        8'h74
`define CFG_SEL2_SET_OFS    8'h78
`define CFG_SEL2_CLR_OFS    8'h7c
`define CFG_SEL3_OFS        8'h80
`define CFG_SEL3_SET_OFS    8'h84
`define CFG_SEL3_CLR_OFS    8'h88
`define HYST_EN_OFS         8'ha8
`define SLEW_SEL_OFS        8'hac
`define DRIVE0_OFS          8'hb0
`define DRIVE1_OFS          8'hb4
`define PULL_EN_OFS         8'hb8
`define STATUS_MASK_OFS     8'hc0
`define STATUS_OFS          8'hc4

// reset values
`define WORD_RST            32'h0000_0000
`define STATUS_RST          2'h0

// bus address width and status bit positions
`define ADDR_W              8
`define ST_FLAG_BIT         0
`define ST_BADADR_BIT       1

`endif

// ==== rtl/gpio_sync_edge.v ====
// synchroniser and edge detector for the port pins
// assumes pins asynchronous to clk; two flip-flops before any logic
`timescale 1ns/10ps
module gpio_sync_edge #(
	parameter WIDTH = 32
) (
	input  wire             clk,
	input  wire             rst,
	input  wire [WIDTH-1:0] pin_async,
	output wire [WIDTH-1:0] level,
	output wire [WIDTH-1:0] rise,
	output wire [WIDTH-1:0] fall
);
	reg [WIDTH-1:0] meta_reg;   // first stage, read only by second
	reg [WIDTH-1:0] sync_reg;   // second stage, safe level
	reg [WIDTH-1:0] prev_reg;   // previous safe level

	// two-stage synchroniser and history
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= {WIDTH{1'b0}};
			sync_reg <= {WIDTH{1'b0}};
			prev_reg <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= pin_async;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign level = sync_reg;
	assign rise  = sync_reg & ~prev_reg;
	assign fall  = ~sync_reg & prev_reg;
endmodule

// ==== rtl/gpio_irq_detect.v ====
// per-pin interrupt trigger decode and sticky flags
// assumes synchronised level and edges from the same clock
`timescale 1ns/10ps
module gpio_irq_detect #(
	parameter WIDTH = 32
) (
	input  wire             clk,
	input  wire             rst,
	input  wire [WIDTH-1:0] level,
	input  wire [WIDTH-1:0] rise,
	input  wire [WIDTH-1:0] fall,
	input  wire [WIDTH-1:0] in_en,
	input  wire [WIDTH-1:0] trig_kind,
	input  wire [WIDTH-1:0] pol,
	input  wire [WIDTH-1:0] both_edges,
	input  wire [WIDTH-1:0] irq_en,
	input  wire [WIDTH-1:0] clr_mask,
	output reg  [WIDTH-1:0] flags,
	output wire             new_event
);
	reg  [WIDTH-1:0] hit;   // per-pin trigger this cycle
	genvar k;

	// each pin decodes only its own bit
	generate
		for (k = 0; k < WIDTH; k = k + 1) begin : g_pin
			always @* begin
				if (both_edges[k])                 // any edge
					hit[k] = rise[k] | fall[k];
				else if (trig_kind[k])             // edge mode, 0 rising
					hit[k] = pol[k] ? fall[k] : rise[k];
				else                               // level mode, 1 high
					hit[k] = pol[k] ? level[k] : ~level[k];
			end
		end
	endgenerate

	wire [WIDTH-1:0] set_mask = hit & in_en & irq_en;

	// sticky flags; a new trigger wins over a clear in the same cycle
	always @(posedge clk or posedge rst) begin
		if (rst)
			flags <= {WIDTH{1'b0}};
		else
			flags <= (flags & ~clr_mask) | set_mask;
	end

	assign new_event = |(set_mask & ~flags);
endmodule

// ==== rtl/gpio_port_bank.v ====
// register bank of one general-purpose i/o port on classic wishbone
// assumes 32-bit byte-addressed wishbone, 10 mhz clk, async active-high rst
//
// Contract
// - each instance owns private register set
// - all fields reset on any reset
// - flags and flag clear split, gap word
// - config select zero word read write
// - select zero by write, set, clear
// - bit k drives pin k only
// - set alias ones force bits high
// - select writes leave pin state alone
// - clear alias ones force bits low
// - mode zero level, one edge, polarity
// - dual edge flags both edges
// - writing one clears pending flag
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/10ps
`include "gpio_port_regs.vh"
module gpio_port_bank #(
	parameter WIDTH = 32
) (
	input  wire                  clk,
	input  wire                  rst,
	input  wire [`ADDR_W-1:0]    wb_adr_i,
	input  wire [31:0]           wb_dat_i,
	input  wire [3:0]            wb_sel_i,
	input  wire                  wb_we_i,
	input  wire                  wb_cyc_i,
	input  wire                  wb_stb_i,
	output reg  [31:0]           wb_dat_o,
	output reg                   wb_ack_o,
	input  wire [WIDTH-1:0]      pin_in,
	output reg  [WIDTH-1:0]      pin_out,
	output reg  [WIDTH-1:0]      pin_oe,
	output reg  [WIDTH-1:0]      alternate_function_sel0,
	output reg  [WIDTH-1:0]      alternate_function_sel1,
	output reg  [WIDTH-1:0]      alternate_function_sel2,
	output reg  [WIDTH-1:0]      alternate_function_sel3,
	output reg  [WIDTH-1:0]      wake_en_out,
	output reg  [WIDTH-1:0]      irq_port,
	output reg                   irq
);
	// all storage is local to this module, so instances never interact
	reg [31:0] config_select_zero_reg;
	reg [31:0] config_select_one_reg;
	reg [31:0] config_select_two_reg;
	reg [31:0] config_select_three_reg;
	reg [31:0] output_driver_enable_reg;
	reg [31:0] output_value_reg;
	reg [31:0] irq_trigger_kind_reg;
	reg [31:0] irq_polarity_reg;
	reg [31:0] input_buffer_enable_reg;
	reg [31:0] irq_enable_reg;
	reg [31:0] wake_enable_reg;
	reg [31:0] irq_both_edges_reg;
	reg [31:0] pad_control_zero_reg;
	reg [31:0] pad_control_one_reg;
	reg [31:0] hyst_en_reg;
	reg [31:0] slew_sel_reg;
	reg [31:0] drive0_reg;
	reg [31:0] drive1_reg;
	reg [31:0] pull_en_reg;
	reg [1:0]  status_reg;       // sticky block events
	reg [1:0]  status_mask_reg;  // event mask, same layout

	// bus qualifiers
	wire        req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire        wr      = req & wb_we_i;
	wire        rd      = req & ~wb_we_i;
	wire [31:0] bmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
	                       {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire [31:0] wdat    = wb_dat_i & bmask; // lane-gated ones for alias access

	// byte-lane merge for direct writes
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [31:0] m;
		begin
			merge = (old & ~m) | (nw & m);
		end
	endfunction

	// write-decode for a given offset
	function hit;
		input [`ADDR_W-1:0] a;
		input [`ADDR_W-1:0] ofs;
		begin
			hit = (a[`ADDR_W-1:2] == ofs[`ADDR_W-1:2]);
		end
	endfunction

	// register with direct write, set alias and clear alias
	function [31:0] rw_sc;
		input [31:0] old;
		input        w_dir;
		input        w_set;
		input        w_clr;
		begin
			rw_sc = old;
			if (w_dir)
				rw_sc = merge(old, wb_dat_i, bmask);
			else if (w_set)
				rw_sc = old | wdat;
			else if (w_clr)
				rw_sc = old & ~wdat;
		end
	endfunction

	// pin side: synchronise and find edges
	wire [WIDTH-1:0] lvl;
	wire [WIDTH-1:0] rise;
	wire [WIDTH-1:0] fall;
	gpio_sync_edge #(.WIDTH(WIDTH)) u_sync (
		.clk       (clk),
		.rst       (rst),
		.pin_async (pin_in),
		.level     (lvl),
		.rise      (rise),
		.fall      (fall)
	);

	// flag clear comes only from the separate clear word
	wire [WIDTH-1:0] flag_clr = (wr && hit(wb_adr_i, `IRQ_FLAGS_CLR_OFS)) ?
	                            wdat[WIDTH-1:0] : {WIDTH{1'b0}};
	wire [WIDTH-1:0] flags;
	wire             pin_event;
	gpio_irq_detect #(.WIDTH(WIDTH)) u_irq (
		.clk        (clk),
		.rst        (rst),
		.level      (lvl),
		.rise       (rise),
		.fall       (fall),
		.in_en      (input_buffer_enable_reg[WIDTH-1:0]),
		.trig_kind  (irq_trigger_kind_reg[WIDTH-1:0]),
		.pol        (irq_polarity_reg[WIDTH-1:0]),
		.both_edges (irq_both_edges_reg[WIDTH-1:0]),
		.irq_en     (irq_enable_reg[WIDTH-1:0]),
		.clr_mask   (flag_clr),
		.flags      (flags),
		.new_event  (pin_event)
	);

	// mapped-offset check for the unmapped-address event
	reg mapped;
	always @* begin
		case (wb_adr_i[`ADDR_W-1:2])
			`CFG_SEL0_OFS >> 2, `CFG_SEL0_SET_OFS >> 2, `CFG_SEL0_CLR_OFS >> 2,
			`OUT_EN_OFS >> 2, `OUT_EN_SET_OFS >> 2, `OUT_EN_CLR_OFS >> 2,
			`OUT_VAL_OFS >> 2, `OUT_VAL_SET_OFS >> 2, `OUT_VAL_CLR_OFS >> 2,
			`PIN_IN_OFS >> 2, `IRQ_KIND_OFS >> 2, `IRQ_POL_OFS >> 2,
			`IN_BUF_EN_OFS >> 2, `IRQ_EN_OFS >> 2, `IRQ_EN_SET_OFS >> 2,
			`IRQ_EN_CLR_OFS >> 2, `IRQ_FLAGS_OFS >> 2, `IRQ_FLAGS_CLR_OFS >> 2,
			`WAKE_EN_OFS >> 2, `WAKE_EN_SET_OFS >> 2, `WAKE_EN_CLR_OFS >> 2,
			`BOTH_EDGES_OFS >> 2, `PAD_CTRL0_OFS >> 2, `PAD_CTRL1_OFS >> 2,
			`CFG_SEL1_OFS >> 2, `CFG_SEL1_SET_OFS >> 2, `CFG_SEL1_CLR_OFS >> 2,
			`CFG_SEL2_OFS >> 2, `CFG_SEL2_SET_OFS >> 2, `CFG_SEL2_CLR_OFS >> 2,
			`CFG_SEL3_OFS >> 2, `CFG_SEL3_SET_OFS >> 2, `CFG_SEL3_CLR_OFS >> 2,
			`HYST_EN_OFS >> 2, `SLEW_SEL_OFS >> 2, `DRIVE0_OFS >> 2,
			`DRIVE1_OFS >> 2, `PULL_EN_OFS >> 2, `STATUS_MASK_OFS >> 2,
			`STATUS_OFS >> 2:
				mapped = 1'b1;
			default:
				mapped = 1'b0;   // gap words such as 0x44
		endcase
	end

	// read mux; aliases read back zero, unassigned words read zero
	reg [31:0] rdata;
	always @* begin
		rdata = 32'h0000_0000;  // default for aliases and gaps
		case (wb_adr_i[`ADDR_W-1:2])
			`CFG_SEL0_OFS >> 2:    rdata = config_select_zero_reg;
			`OUT_EN_OFS >> 2:      rdata = output_driver_enable_reg;
			`OUT_VAL_OFS >> 2:     rdata = output_value_reg;
			`PIN_IN_OFS >> 2:      rdata[WIDTH-1:0] = lvl;
			`IRQ_KIND_OFS >> 2:    rdata = irq_trigger_kind_reg;
			`IRQ_POL_OFS >> 2:     rdata = irq_polarity_reg;
			`IN_BUF_EN_OFS >> 2:   rdata = input_buffer_enable_reg;
			`IRQ_EN_OFS >> 2:      rdata = irq_enable_reg;
			`IRQ_FLAGS_OFS >> 2:   rdata[WIDTH-1:0] = flags;
			`WAKE_EN_OFS >> 2:     rdata = wake_enable_reg;
			`BOTH_EDGES_OFS >> 2:  rdata = irq_both_edges_reg;
			`PAD_CTRL0_OFS >> 2:   rdata = pad_control_zero_reg;
			`PAD_CTRL1_OFS >> 2:   rdata = pad_control_one_reg;
			`CFG_SEL1_OFS >> 2:    rdata = config_select_one_reg;
			`CFG_SEL2_OFS >> 2:    rdata = config_select_two_reg;
			`CFG_SEL3_OFS >> 2:    rdata = config_select_three_reg;
			`HYST_EN_OFS >> 2:     rdata = hyst_en_reg;
			`SLEW_SEL_OFS >> 2:    rdata = slew_sel_reg;
			`DRIVE0_OFS >> 2:      rdata = drive0_reg;
			`DRIVE1_OFS >> 2:      rdata = drive1_reg;
			`PULL_EN_OFS >> 2:     rdata = pull_en_reg;
			`STATUS_MASK_OFS >> 2: rdata[1:0] = status_mask_reg;
			`STATUS_OFS >> 2:      rdata[1:0] = status_reg;
			default:               rdata = 32'h0000_0000;
		endcase
	end

	// write strobes per offset; every write lands at the edge that raises ack,
	// so a request once taken cannot be withdrawn by the master
	wire wa  = wr;
	// status events: bit one for a touch of an unmapped word, bit zero for a new pin flag
	wire [1:0] ev_set = {req & ~mapped, pin_event};

	// single-cycle wishbone answer, one wait-free ack per request
	// ack never stands two cycles: the request term excludes a pending ack
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= `WORD_RST;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= rd ? rdata : `WORD_RST;
		end
	end

	// configuration registers; every field returns to zero on reset
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			config_select_zero_reg   <= `WORD_RST;
			config_select_one_reg    <= `WORD_RST;
			config_select_two_reg    <= `WORD_RST;
			config_select_three_reg  <= `WORD_RST;
			output_driver_enable_reg <= `WORD_RST;
			output_value_reg         <= `WORD_RST;
			irq_trigger_kind_reg     <= `WORD_RST;
			irq_polarity_reg         <= `WORD_RST;
			input_buffer_enable_reg  <= `WORD_RST;
			irq_enable_reg           <= `WORD_RST;
			wake_enable_reg          <= `WORD_RST;
			irq_both_edges_reg       <= `WORD_RST;
			pad_control_zero_reg     <= `WORD_RST;
			pad_control_one_reg      <= `WORD_RST;
			hyst_en_reg              <= `WORD_RST;
			slew_sel_reg             <= `WORD_RST;
			drive0_reg               <= `WORD_RST;
			drive1_reg               <= `WORD_RST;
			pull_en_reg              <= `WORD_RST;
			status_mask_reg          <= `STATUS_RST;
		end else begin
			// select zero: direct, set alias, clear alias
			config_select_zero_reg <= rw_sc(config_select_zero_reg,
				wa && hit(wb_adr_i, `CFG_SEL0_OFS),
				wa && hit(wb_adr_i, `CFG_SEL0_SET_OFS),
				wa && hit(wb_adr_i, `CFG_SEL0_CLR_OFS));
			config_select_one_reg <= rw_sc(config_select_one_reg,
				wa && hit(wb_adr_i, `CFG_SEL1_OFS),
				wa && hit(wb_adr_i, `CFG_SEL1_SET_OFS),
				wa && hit(wb_adr_i, `CFG_SEL1_CLR_OFS));
			config_select_two_reg <= rw_sc(config_select_two_reg,
				wa && hit(wb_adr_i, `CFG_SEL2_OFS),
				wa && hit(wb_adr_i, `CFG_SEL2_SET_OFS),
				wa && hit(wb_adr_i, `CFG_SEL2_CLR_OFS));
			config_select_three_reg <= rw_sc(config_select_three_reg,
				wa && hit(wb_adr_i, `CFG_SEL3_OFS),
				wa && hit(wb_adr_i, `CFG_SEL3_SET_OFS),
				wa && hit(wb_adr_i, `CFG_SEL3_CLR_OFS));
			output_driver_enable_reg <= rw_sc(output_driver_enable_reg,
				wa && hit(wb_adr_i, `OUT_EN_OFS),
				wa && hit(wb_adr_i, `OUT_EN_SET_OFS),
				wa && hit(wb_adr_i, `OUT_EN_CLR_OFS));
			output_value_reg <= rw_sc(output_value_reg,
				wa && hit(wb_adr_i, `OUT_VAL_OFS),
				wa && hit(wb_adr_i, `OUT_VAL_SET_OFS),
				wa && hit(wb_adr_i, `OUT_VAL_CLR_OFS));
			irq_enable_reg <= rw_sc(irq_enable_reg,
				wa && hit(wb_adr_i, `IRQ_EN_OFS),
				wa && hit(wb_adr_i, `IRQ_EN_SET_OFS),
				wa && hit(wb_adr_i, `IRQ_EN_CLR_OFS));
			wake_enable_reg <= rw_sc(wake_enable_reg,
				wa && hit(wb_adr_i, `WAKE_EN_OFS),
				wa && hit(wb_adr_i, `WAKE_EN_SET_OFS),
				wa && hit(wb_adr_i, `WAKE_EN_CLR_OFS));
			// plain read-write words
			if (wa && hit(wb_adr_i, `IRQ_KIND_OFS))
				irq_trigger_kind_reg <= merge(irq_trigger_kind_reg, wb_dat_i, bmask);
			if (wa && hit(wb_adr_i, `IRQ_POL_OFS))
				irq_polarity_reg <= merge(irq_polarity_reg, wb_dat_i, bmask);
			if (wa && hit(wb_adr_i, `IN_BUF_EN_OFS))
				input_buffer_enable_reg <= merge(input_buffer_enable_reg, wb_dat_i, bmask);
			if (wa && hit(wb_adr_i, `BOTH_EDGES_OFS))
				irq_both_edges_reg <= merge(irq_both_edges_reg, wb_dat_i, bmask);
			if (wa && hit(wb_adr_i, `PAD_CTRL0_OFS))
				pad_control_zero_reg <= merge(pad_control_zero_reg, wb_dat_i, bmask);
			if (wa && hit(wb_adr_i, `PAD_CTRL1_OFS))
				pad_control_one_reg <= merge(pad_control_one_reg, wb_dat_i, bmask);
			if (wa && hit(wb_adr_i, `HYST_EN_OFS))
				hyst_en_reg <= merge(hyst_en_reg, wb_dat_i, bmask);
			if (wa && hit(wb_adr_i, `SLEW_SEL_OFS))
				slew_sel_reg <= merge(slew_sel_reg, wb_dat_i, bmask);
			if (wa && hit(wb_adr_i, `DRIVE0_OFS))
				drive0_reg <= merge(drive0_reg, wb_dat_i, bmask);
			if (wa && hit(wb_adr_i, `DRIVE1_OFS))
				drive1_reg <= merge(drive1_reg, wb_dat_i, bmask);
			if (wa && hit(wb_adr_i, `PULL_EN_OFS))
				pull_en_reg <= merge(pull_en_reg, wb_dat_i, bmask);
			if (wa && hit(wb_adr_i, `STATUS_MASK_OFS) && wb_sel_i[0])
				status_mask_reg <= wb_dat_i[1:0];
		end
	end

	// sticky status; read clears, a new event in the same cycle wins
	// a read that meets a new event keeps that event, so none is lost
	always @(posedge clk or posedge rst) begin
		if (rst)
			status_reg <= `STATUS_RST;
		else if (rd && hit(wb_adr_i, `STATUS_OFS))
			status_reg <= ev_set;
		else
			status_reg <= status_reg | ev_set;
	end

	// pin-facing outputs, registered; bit k of each word goes to pin k only
	// every pin-facing output is one cycle behind its register word
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_out                 <= {WIDTH{1'b0}};
			pin_oe                  <= {WIDTH{1'b0}};
			alternate_function_sel0 <= {WIDTH{1'b0}};
			alternate_function_sel1 <= {WIDTH{1'b0}};
			alternate_function_sel2 <= {WIDTH{1'b0}};
			alternate_function_sel3 <= {WIDTH{1'b0}};
			wake_en_out             <= {WIDTH{1'b0}};
			irq_port                <= {WIDTH{1'b0}};
			irq                     <= 1'b0;
		end else begin
			// pin drive follows only the output words, never the selects
			pin_out                 <= output_value_reg[WIDTH-1:0];
			pin_oe                  <= output_driver_enable_reg[WIDTH-1:0];
			alternate_function_sel0 <= config_select_zero_reg[WIDTH-1:0];
			alternate_function_sel1 <= config_select_one_reg[WIDTH-1:0];
			alternate_function_sel2 <= config_select_two_reg[WIDTH-1:0];
			alternate_function_sel3 <= config_select_three_reg[WIDTH-1:0];
			wake_en_out             <= wake_enable_reg[WIDTH-1:0];
			irq_port                <= flags;
			irq                     <= |(status_reg & status_mask_reg);
		end
	end
endmodule

// ==== dv/gpio_port_bank_asserts.sv ====
// concurrent checks on the ports of the gpio port register bank
// assumes a classic wishbone master that holds each request until ack
`timescale 1ns/10ps
`include "gpio_port_regs.vh"
module gpio_port_bank_asserts #(
	parameter WIDTH = 32
) (
	input wire               clk,
	input wire               rst,
	input wire [`ADDR_W-1:0] wb_adr_i,
	input wire [31:0]        wb_dat_i,
	input wire [3:0]         wb_sel_i,
	input wire               wb_we_i,
	input wire               wb_cyc_i,
	input wire               wb_stb_i,
	input wire [31:0]        wb_dat_o,
	input wire               wb_ack_o,
	input wire [WIDTH-1:0]   pin_out,
	input wire [WIDTH-1:0]   pin_oe,
	input wire [WIDTH-1:0]   alternate_function_sel0,
	input wire [WIDTH-1:0]   irq_port,
	input wire               irq
);
	reg  [31:0] wd_q;   // write data of the last acked cycle
	reg  [31:0] old_q;  // select-zero copy just before that cycle
	wire [5:0]  wa = wb_adr_i[7:2];  // word index
	wire        req = wb_cyc_i & wb_stb_i;
	wire        wr_ack = wb_ack_o & req & wb_we_i & (wb_sel_i == 4'hf);
	// capture what an acked write carried and what it replaced
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wd_q  <= 32'h0000_0000;
			old_q <= 32'h0000_0000;
		end else if (wb_ack_o) begin
			wd_q  <= wb_dat_i;
			old_q <= alternate_function_sel0;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_reset_outputs_zero: assert property ($fell(rst) |->
		!wb_ack_o && pin_out == 0 && pin_oe == 0 && alternate_function_sel0 == 0 && !irq)
		else $error("outputs not clear after reset");
	a_ack_next_cycle: assert property (req && !wb_ack_o |=> wb_ack_o)
		else $error("no ack one cycle after request");
	a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_sel0_direct_write: assert property (wr_ack && wa == 6'h00 |->
		##[1:2] alternate_function_sel0 == wd_q)
		else $error("select zero write lost");
	a_sel0_set_alias: assert property (wr_ack && wa == 6'h01 |->
		##[1:2] alternate_function_sel0 == (old_q | wd_q))
		else $error("set alias wrong");
	a_sel0_clear_alias: assert property (wr_ack && wa == 6'h02 |->
		##[1:2] alternate_function_sel0 == (old_q & ~wd_q))
		else $error("clear alias wrong");
	a_sel_keeps_pins: assert property (wr_ack && wa <= 6'h02 |=>
		($stable(pin_out) && $stable(pin_oe)) [*2])
		else $error("pin state moved on select write");
	a_gap_reads_zero: assert property (
		wb_ack_o && !wb_we_i && (wa == 6'h11 || wa == 6'h23) |-> wb_dat_o == 0)
		else $error("unassigned word not zero");
	a_flag_clear_works: assert property (wr_ack && wa == 6'h12 |->
		##[1:3] (irq_port & wd_q) == 0)
		else $error("flag not cleared");
	a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 0)
		else $error("read data outside ack");
endmodule
bind gpio_port_bank gpio_port_bank_asserts #(.WIDTH(WIDTH)) u_chk (.clk(clk), .rst(rst),
	.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.pin_out(pin_out), .pin_oe(pin_oe), .alternate_function_sel0(alternate_function_sel0),
	.irq_port(irq_port), .irq(irq));

// ==== dv/gpio_port_bank_tb.sv ====
// self-checking bench for the gpio port register bank
// assumes the bank answers every wishbone request; the master waits for each ack
`timescale 1ns/10ps
module gpio_port_bank_tb;
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	reg  [7:0]  adr = 8'h00;
	reg  [31:0] dat = 32'h0000_0000;
	reg  [3:0]  sel = 4'hf;  // whole words only
	reg         we = 1'b0;
	reg         cyc = 1'b0;
	reg         stb = 1'b0;
	reg  [31:0] pin_in = 32'h0000_0000;
	wire [31:0] rdat, p_out, p_oe, af0, af1, af2, af3, wk, flg;
	wire [31:0] rdat_a, rdat_b, af0_b;  // per-port read data, second port select zero
	wire        ack, ack_a, ack_b, irq;
	reg         pick = 1'b0;  // steers the bus to the second port
	assign ack  = pick ? ack_b : ack_a;
	assign rdat = pick ? rdat_b : rdat_a;
	integer     miscompares = 0;
	integer     n_compared = 0;
	integer     cycles = 0;
	integer     i;
	reg  [31:0] q;
	gpio_port_bank DUT (.clk(clk), .rst(rst), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
		.wb_we_i(we), .wb_cyc_i(cyc & ~pick), .wb_stb_i(stb), .wb_dat_o(rdat_a),
		.wb_ack_o(ack_a), .pin_in(pin_in), .pin_out(p_out), .pin_oe(p_oe),
		.alternate_function_sel0(af0), .alternate_function_sel1(af1),
		.alternate_function_sel2(af2), .alternate_function_sel3(af3),
		.wake_en_out(wk), .irq_port(flg), .irq(irq));
	// second port on the same bus, reached only while pick is high
	gpio_port_bank other_port (.clk(clk), .rst(rst), .wb_adr_i(adr), .wb_dat_i(dat),
		.wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc & pick), .wb_stb_i(stb),
		.wb_dat_o(rdat_b), .wb_ack_o(ack_b), .pin_in(pin_in), .pin_out(), .pin_oe(),
		.alternate_function_sel0(af0_b), .alternate_function_sel1(),
		.alternate_function_sel2(), .alternate_function_sel3(), .wake_en_out(),
		.irq_port(), .irq());
	// 10 mhz clock
	initial begin
		forever #50 clk = ~clk;
	end
	// hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			miscompares = miscompares + 1;
			report_and_stop;
		end
	end
	task report_and_stop;
		begin
			$display("compared %0d mismatches %0d", n_compared, miscompares);
			if (miscompares == 0 && n_compared > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				miscompares = miscompares + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	// one classic cycle, held until ack, then a idle cycle
	task bus(input w, input [7:0] a, input [31:0] d);
		integer n;
		begin
			adr <= a;
			dat <= d;
			we <= w;
			cyc <= 1'b1;
			stb <= 1'b1;
			n = 0;
			@(posedge clk);
			while (ack !== 1'b1 && n < 20) begin
				@(posedge clk);
				n = n + 1;
			end
			q = rdat;
			if (n == 20)
				chk(32'hdead_0000, 32'h0000_0000);
			cyc <= 1'b0;
			stb <= 1'b0;
			we <= 1'b0;
			@(posedge clk);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rc(input [7:0] a, input [31:0] e);
		begin
			bus(1'b0, a, 32'h0000_0000);
			chk(q, e);
		end
	endtask
	// every word from 0x00 to 0xc0 reads zero out of reset
	task t_reset;
		for (i = 0; i <= 8'hc0; i = i + 4)
			rc(i[7:0], 32'h0000_0000);
	endtask
	// unassigned words, read-only input, unmapped status
	task t_gap;
		begin
			wr(8'h44, 32'hffff_ffff);
			wr(8'h58, 32'hffff_ffff);
			wr(8'h8c, 32'hffff_ffff);
			wr(8'h24, 32'hffff_ffff);
			rc(8'h44, 32'h0000_0000);
			rc(8'h58, 32'h0000_0000);
			rc(8'h8c, 32'h0000_0000);
			rc(8'h24, 32'h0000_0000);
			rc(8'hc4, 32'h0000_0002);
			rc(8'hc4, 32'h0000_0000);
		end
	endtask
	// direct write then set and clear aliases on every aliased register
	task t_alias;
		reg [7:0] b;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				b = 8'(64'h8074_684c_3418_0c00 >> (i * 8));
				wr(b, 32'h0f0f_0f0f);
				if (i == 0)
					chk(p_out | p_oe, 32'h0000_0000);
				wr(b + 8'h04, 32'h3000_0000);
				wr(b + 8'h08, 32'h0000_0003);
				rc(b, 32'h3f0f_0f0c);
				rc(b + 8'h04, 32'h0000_0000);
			end
			chk(af0, 32'h3f0f_0f0c);
			chk(p_oe & p_out & wk, 32'h3f0f_0f0c);
			chk(af1 & af2 & af3, 32'h3f0f_0f0c);
			wr(8'h04, 32'hc0f0_f0f3);
			chk(p_out & p_oe, 32'h3f0f_0f0c);
			chk(af0, 32'hffff_ffff);
			wr(8'h34, 32'h0000_0000);
		end
	endtask
	// plain read-write words
	task t_plain;
		reg [7:0] b;
		begin
			for (i = 0; i < 11; i = i + 1) begin
				b = 8'(88'hb8b4_b0ac_a864_605c_302c_28 >> (i * 8));
				wr(b, {4{b}});
				rc(b, {4{b}});
				wr(b, 32'h0000_0000);
			end
		end
	endtask
	// trigger kinds, polarity, both edges, clear, mask
	task t_irq;
		begin
			wr(8'h30, 32'h0000_00ff);
			wr(8'h28, 32'h0000_0013);
			wr(8'h2c, 32'h0000_0006);
			wr(8'h5c, 32'h0000_0010);
			wr(8'hc0, 32'h0000_0001);
			wr(8'h34, 32'h0000_001f);
			pin_in <= 32'h0000_0017;
			repeat (5) @(posedge clk);
			rc(8'h24, 32'h0000_0017);
			rc(8'h40, 32'h0000_001d);
			chk({31'h0, irq}, 32'h0000_0001);
			wr(8'h34, 32'h0000_0000);
			wr(8'h48, 32'h0000_00ff);
			rc(8'h40, 32'h0000_0000);
			rc(8'hc4, 32'h0000_0001);
			@(posedge clk);
			chk({31'h0, irq}, 32'h0000_0000);
			wr(8'hc0, 32'h0000_0000);
			wr(8'h34, 32'h0000_0012);
			pin_in <= 32'h0000_0000;
			repeat (5) @(posedge clk);
			rc(8'h40, 32'h0000_0012);
			chk({31'h0, irq}, 32'h0000_0000);
			wr(8'hc0, 32'h0000_0001);
			@(posedge clk);
			chk({31'h0, irq}, 32'h0000_0001);
			wr(8'h34, 32'h0000_0000);
			wr(8'h48, 32'h0000_00ff);
			chk(flg, 32'h0000_0000);
		end
	endtask
	// a second port keeps its own words apart from the first
	task t_inst;
		begin
			pick <= 1'b1;
			rc(8'h00, 32'h0000_0000);
			wr(8'h00, 32'h0000_00a5);
			rc(8'h00, 32'h0000_00a5);
			chk(af0_b, 32'h0000_00a5);
			pick <= 1'b0;
			rc(8'h00, 32'hffff_ffff);
			chk(af0, 32'hffff_ffff);
		end
	endtask
	// reset in mid-run returns written words and outputs to zero
	task t_rerst;
		begin
			rst <= 1'b1;
			repeat (2) @(posedge clk);
			rst <= 1'b0;
			@(posedge clk);
			rc(8'h00, 32'h0000_0000);
			rc(8'h0c, 32'h0000_0000);
			rc(8'hc0, 32'h0000_0000);
			chk(p_out | p_oe | af0 | flg, 32'h0000_0000);
			chk({31'h0, irq}, 32'h0000_0000);
		end
	endtask
	// main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset;
		t_gap;
		t_alias;
		t_plain;
		t_irq;
		t_inst;
		t_rerst;
		report_and_stop;
	end
endmodule
